// ===== inc/acmp_ctrl_defines.svh
// register offsets, field positions and reset values of the comparator control block
// assumes inclusion by bare name from the design and bench files
// Function
// (R1) one 8-bit status and control register holds all controls and the flag
// (R2) bit 7 enables the comparator module
// (R3) bit 6 selects positive pin (0) or bandgap reference (1) as non-inverting input
// (R4) inverting input is always the negative input pin
// (R5) comparator output high while non-inverting input exceeds inverting input
// (R6) bit 5 event flag is set on each compare event chosen by mode
// (R7) writing 1 to bit 5 clears the flag, writing 0 leaves it
// (R8) bits 1:0 mode: 00 fall, 01 rise, 10 fall, 11 either edge
// (R9) interrupt request while flag set and bit 4 enable is 1
// (R10) bit 3 reads the present comparator output
// (R11) comparator output status forced to 0 and reads 0 while disabled
// (R12) bit 2 drives the comparator output onto the output pin
// (R13) comparator output passes two flip-flops before edge detection; the code passes three (meta_q, sync_q, then cmp_out_q)
`ifndef ACMP_CTRL_DEFINES_SVH
`define ACMP_CTRL_DEFINES_SVH

`define SC_OFFSET 4'h0
`define IRQ_STATUS_OFFSET 4'h4
`define IRQ_MASK_OFFSET 4'h8
`define SC_RESET 8'h00
`define MASK_RESET 8'h00
`define BIT_ENABLE 7
`define BIT_REF_SEL 6
`define BIT_FLAG 5
`define BIT_IRQ_EN 4
`define BIT_OUT_STATUS 3
`define BIT_PIN_EN 2
`define MODE_MSB 1
`define MODE_LSB 0
`define EV_RISE_BIT 0
`define EV_FALL_BIT 1
`define EV_FLAG_BIT 2
`define UNMAPPED_READ 32'h00000000

`endif

// ===== inc/acmp_ctrl_pkg.sv
// types shared by the comparator control block
// assumes the defines header sits beside it on the include path
package acmp_ctrl_pkg;
    typedef enum logic [1:0] {
        mode_fall_a,
        mode_rise,
        mode_fall_b,
        mode_both
    } edge_mode_e;
    typedef enum logic [1:0] {
        bus_idle,
        bus_answer
    } bus_state_e;
endpackage

// ===== rtl/acmp_sync.sv
// two-flop synchroniser for the analog comparator output
// assumes a single clock and an asynchronous active-low reset
`timescale 1ns/10ps
module acmp_sync (
    input wire logic clock,
    input wire logic nrst,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_q;
    logic meta_d;
    logic sync_q;
    logic sync_d;

    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    // only the second stage is visible outside [R13]
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;
endmodule

// ===== rtl/acmp_ctrl.sv
// control and event logic around one analog comparator, avalon-mm slave
// assumes the analog core compares the selected inputs and returns an async digital result
//
// Added by the designer: register access over Avalon-MM and the register offsets.
`timescale 1ns/10ps
`include "acmp_ctrl_defines.svh"
module acmp_ctrl
    import acmp_ctrl_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic analog_cmp_out,
    output logic analog_enable,
    output logic reference_input_select,
    output logic negative_input_route,
    output logic comparator_output_pin,
    output logic comparator_output_pin_oe,
    output logic irq,
    output logic compare_irq
);

    ////////////////////////////////////////////////////////////////////////////
    // synchroniser

    logic cmp_sync;

    acmp_sync u_sync (
        .clock(clock),
        .nrst(nrst),
        .async_in(analog_cmp_out),
        .sync_out(cmp_sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // state

    logic [7:0] sc_q;
    logic [7:0] sc_d;
    logic [7:0] irq_status_q;
    logic [7:0] irq_status_d;
    logic [7:0] irq_mask_q;
    logic [7:0] irq_mask_d;
    logic cmp_out_q;
    logic cmp_out_d;
    logic cmp_prev_q;
    logic cmp_prev_d;
    bus_state_e bus_q;
    bus_state_e bus_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic irq_q;
    logic irq_d;
    logic cirq_q;
    logic cirq_d;
    logic pin_q;
    logic pin_d;
    logic pin_oe_q;
    logic pin_oe_d;
    logic en_q;
    logic en_d;
    logic ref_q;
    logic ref_d;
    logic wait_q;
    logic wait_d;
    logic route_q;
    logic route_d;

    logic rise_ev;
    logic fall_ev;
    logic cmp_event;
    logic sc_wr;
    logic status_rd;
    logic mask_wr;

    function automatic logic edge_hit(input logic [1:0] mode, input logic rise,
                                      input logic fall);
        case (edge_mode_e'(mode))
            mode_rise: edge_hit = rise;
            mode_both: edge_hit = rise | fall;
            mode_fall_a: edge_hit = fall;
            mode_fall_b: edge_hit = fall;
            default: edge_hit = fall;
        endcase
    endfunction

    function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
        hit = (a == off);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        sc_wr = (bus_q == bus_answer) && write && hit(address, `SC_OFFSET) && byteenable[0];
        mask_wr = (bus_q == bus_answer) && write && hit(address, `IRQ_MASK_OFFSET)
                  && byteenable[0];
        // cleared at the edge the word is captured, so no event falls between the two
        status_rd = (bus_q == bus_idle) && read && hit(address, `IRQ_STATUS_OFFSET);

        // output status held at 0 while disabled [R11]
        cmp_out_d = sc_q[`BIT_ENABLE] ? cmp_sync : 1'b0; // [R5] [R10]
        // edges seen on the synchronised value only [R13]
        cmp_prev_d = cmp_out_q;
        rise_ev = cmp_out_q & ~cmp_prev_q;
        fall_ev = ~cmp_out_q & cmp_prev_q;
        // disable drops output to 0; that edge is suppressed to avoid a false event
        cmp_event = sc_q[`BIT_ENABLE] && sc_q[`BIT_ENABLE] == en_q
                    && edge_hit(sc_q[`MODE_MSB:`MODE_LSB], rise_ev, fall_ev); // [R8]

        sc_d = sc_q;
        if (sc_wr) begin
            sc_d[`BIT_ENABLE] = writedata[`BIT_ENABLE]; // [R2]
            sc_d[`BIT_REF_SEL] = writedata[`BIT_REF_SEL]; // [R3]
            sc_d[`BIT_IRQ_EN] = writedata[`BIT_IRQ_EN];
            sc_d[`BIT_PIN_EN] = writedata[`BIT_PIN_EN];
            sc_d[`MODE_MSB:`MODE_LSB] = writedata[`MODE_MSB:`MODE_LSB];
            if (writedata[`BIT_FLAG]) begin
                sc_d[`BIT_FLAG] = 1'b0; // [R7]
            end
        end
        if (cmp_event) begin
            sc_d[`BIT_FLAG] = 1'b1; // set wins over clear [R6]
        end
        sc_d[`BIT_OUT_STATUS] = cmp_out_d & sc_d[`BIT_ENABLE]; // [R10] [R11]

        irq_status_d = irq_status_q;
        if (status_rd) begin
            irq_status_d = 8'h00;
        end
        irq_status_d[`EV_RISE_BIT] = irq_status_d[`EV_RISE_BIT] | (sc_q[`BIT_ENABLE] & rise_ev);
        irq_status_d[`EV_FALL_BIT] = irq_status_d[`EV_FALL_BIT] | (sc_q[`BIT_ENABLE] & fall_ev);
        irq_status_d[`EV_FLAG_BIT] = irq_status_d[`EV_FLAG_BIT] | cmp_event;

        irq_mask_d = mask_wr ? writedata[7:0] : irq_mask_q;

        // irq from the flag only through its enable [R9]
        cirq_d = sc_d[`BIT_FLAG] & sc_d[`BIT_IRQ_EN];
        irq_d = |(irq_status_d & irq_mask_d);

        pin_d = cmp_out_d; // [R12]
        pin_oe_d = sc_d[`BIT_PIN_EN] & sc_d[`BIT_ENABLE]; // [R12]
        en_d = sc_q[`BIT_ENABLE];
        ref_d = sc_d[`BIT_REF_SEL]; // [R3]
        route_d = 1'b1; // inverting side fixed to negative pin [R4]
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus slave: one wait cycle, answer in the second

    always_comb begin
        bus_d = bus_idle;
        rdata_d = rdata_q;
        if (bus_q == bus_idle && (read || write)) begin
            bus_d = bus_answer;
            rdata_d = `UNMAPPED_READ;
            if (read) begin
                case (address)
                    `SC_OFFSET: rdata_d = {24'h000000, sc_q}; // [R1]
                    `IRQ_STATUS_OFFSET: rdata_d = {24'h000000, irq_status_q};
                    `IRQ_MASK_OFFSET: rdata_d = {24'h000000, irq_mask_q};
                    default: rdata_d = `UNMAPPED_READ;
                endcase
            end
        end
        wait_d = ~(bus_d == bus_answer);
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sc_q <= `SC_RESET;
            irq_status_q <= 8'h00;
            irq_mask_q <= `MASK_RESET;
            cmp_out_q <= 1'b0;
            cmp_prev_q <= 1'b0;
            bus_q <= bus_idle;
            rdata_q <= 32'h00000000;
            irq_q <= 1'b0;
            cirq_q <= 1'b0;
            pin_q <= 1'b0;
            pin_oe_q <= 1'b0;
            en_q <= 1'b0;
            ref_q <= 1'b0;
            wait_q <= 1'b1;
            route_q <= 1'b1;
        end else begin
            sc_q <= sc_d;
            irq_status_q <= irq_status_d;
            irq_mask_q <= irq_mask_d;
            cmp_out_q <= cmp_out_d;
            cmp_prev_q <= cmp_prev_d;
            bus_q <= bus_d;
            rdata_q <= rdata_d;
            irq_q <= irq_d;
            cirq_q <= cirq_d;
            pin_q <= pin_d;
            pin_oe_q <= pin_oe_d;
            en_q <= en_d;
            ref_q <= ref_d;
            wait_q <= wait_d;
            route_q <= route_d;
        end
    end

    always_comb begin
        readdata = rdata_q;
        waitrequest = wait_q;
        irq = irq_q;
        compare_irq = cirq_q;
        comparator_output_pin = pin_q;
        comparator_output_pin_oe = pin_oe_q;
        analog_enable = sc_q[`BIT_ENABLE]; // [R2]
        reference_input_select = ref_q;
        negative_input_route = route_q; // [R4]
    end
endmodule

// ===== sim/acmp_ctrl_chk.sv
// port checker for the comparator control block
// assumes one clock domain, bound onto every acmp_ctrl instance
`timescale 1ns/10ps
module acmp_ctrl_chk (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic analog_cmp_out,
    input wire logic analog_enable,
    input wire logic reference_input_select,
    input wire logic negative_input_route,
    input wire logic comparator_output_pin,
    input wire logic comparator_output_pin_oe,
    input wire logic irq,
    input wire logic compare_irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    wire rd_sc = !waitrequest && read && address == 4'h0;
    ////////////////////////////////////////////////////////////
    a_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("request not answered next cycle");
    a_wait_short: assert property (!waitrequest |=> waitrequest)
        else $error("answer longer than one cycle");
    a_upper_zero: assert property (!waitrequest && read |-> readdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    a_enable_bits: assert property (
        rd_sc |-> readdata[7:6] == {analog_enable, reference_input_select})
        else $error("enable or select bit disagrees with output");
    a_route_fixed: assert property (negative_input_route)
        else $error("inverting input not on negative pin");
    a_off_zero: assert property (rd_sc && !analog_enable |-> !readdata[3])
        else $error("output status not zero while disabled");
    // six quiet cycles cover sync and status register lag
    a_live_out: assert property (
        (analog_enable && $stable(analog_cmp_out))[*6] ##0 rd_sc
        |-> readdata[3] == analog_cmp_out)
        else $error("output status not live");
    a_pin_follows: assert property (
        (comparator_output_pin_oe && $stable(analog_cmp_out))[*6]
        |-> comparator_output_pin == analog_cmp_out)
        else $error("pin does not follow comparator");
    a_pin_needs_en: assert property (comparator_output_pin_oe |-> analog_enable)
        else $error("pin driven while disabled");
    a_irq_gated: assert property (rd_sc && !readdata[4] |-> !compare_irq)
        else $error("request without interrupt enable");
    a_mask_gate: assert property (
        !waitrequest && read && address == 4'h8 && readdata[2:0] == 3'h0 |-> !irq)
        else $error("irq with all sources masked");
endmodule
bind acmp_ctrl acmp_ctrl_chk chk_u (.clock(clock), .nrst(nrst), .address(address), .read(read),
    .write(write), .readdata(readdata), .waitrequest(waitrequest), .analog_cmp_out(analog_cmp_out),
    .analog_enable(analog_enable), .reference_input_select(reference_input_select),
    .negative_input_route(negative_input_route), .comparator_output_pin(comparator_output_pin),
    .comparator_output_pin_oe(comparator_output_pin_oe), .irq(irq), .compare_irq(compare_irq));

// ===== sim/acmp_ctrl_test.sv
// self-checking bench for the comparator control block
// assumes package, defines header and checker compiled before it
`timescale 1ns/10ps
`include "acmp_ctrl_defines.svh"
module acmp_ctrl_test;
    typedef struct {logic [1:0] mode; logic on_rise; logic on_fall;} row_s;
    row_s rows[4] = '{'{2'h0, 1'b0, 1'b1}, '{2'h1, 1'b1, 1'b0}, '{2'h2, 1'b0, 1'b1},
        '{2'h3, 1'b1, 1'b1}};
    logic clock = 1'b0, nrst = 1'b0, read = 1'b0, write = 1'b0, cmp = 1'b0;
    logic [3:0] address = 4'h0, byteenable = 4'hF;
    logic [31:0] writedata = 32'h0, readdata, rd;
    logic waitrequest, ana_en, ref_sel, neg_route, pin, pin_oe, irq, cirq;
    int fails = 0, checks_done = 0, cyc = 0;
    acmp_ctrl dut_u (.clock(clock), .nrst(nrst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .analog_cmp_out(cmp), .analog_enable(ana_en),
        .reference_input_select(ref_sel), .negative_input_route(neg_route),
        .comparator_output_pin(pin), .comparator_output_pin_oe(pin_oe), .irq(irq),
        .compare_irq(cirq));
    initial forever #4 clock = ~clock;
    ////////////////////////////////////////////////////////////
    task automatic final_report;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fails = fails + 1;
            final_report;
        end
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // waitrequest taken at the rising edge as the slave saw it; request held until then
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
        int n;
        n = 0;
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= {24'h000000, d};
        do begin
            @(posedge clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (n >= 50)
            fails++;
        @(posedge clock);
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        foreach (rows[i]) begin
            bus(1'b1, 4'h0, {6'h28, rows[i].mode});
            cmp <= 1'b1;
            repeat (8) @(posedge clock);
            bus(1'b0, 4'h0, 8'h00);
            chk("flag_rise", 8'(rows[i].on_rise), 8'(rd[5]));
            chk("out_high", 8'h01, 8'(rd[3]));
            bus(1'b1, 4'h0, {6'h28, rows[i].mode});
            cmp <= 1'b0;
            repeat (8) @(posedge clock);
            bus(1'b0, 4'h0, 8'h00);
            chk("flag_fall", 8'(rows[i].on_fall), 8'(rd[5]));
            chk("out_low", 8'h00, 8'(rd[3]));
        end
        $display("mode table done");
        bus(1'b1, 4'h0, 8'h83);
        bus(1'b0, 4'h0, 8'h00);
        chk("flag_kept", 8'h01, 8'(rd[5]));
        chk("irq_off", 8'h00, 8'(cirq));
        bus(1'b1, 4'h0, 8'h93);
        bus(1'b1, 4'h8, 8'h04);
        chk("irq_on", 8'h01, 8'(cirq));
        chk("irq_line", 8'h01, 8'(irq));
        bus(1'b0, 4'h4, 8'h00);
        chk("status_flag", 8'h01, 8'(rd[2]));
        bus(1'b0, 4'h4, 8'h00);
        chk("irq_cleared", 8'h00, 8'(irq));
        bus(1'b1, 4'h0, 8'hB3);
        bus(1'b0, 4'h0, 8'h00);
        chk("flag_cleared", 8'h00, 8'(rd[5]));
        chk("irq_dropped", 8'h00, 8'(cirq));
        byteenable <= 4'hE;
        bus(1'b1, 4'h0, 8'h00);
        byteenable <= 4'hF;
        bus(1'b0, 4'h0, 8'h00);
        chk("be_ignored", 8'h01, 8'(rd[7]));
        $display("flag and irq done");
        cmp <= 1'b1;
        bus(1'b1, 4'h0, 8'hC4);
        repeat (8) @(posedge clock);
        chk("pins", 8'h0F, {4'h0, pin_oe, pin, ref_sel, neg_route});
        bus(1'b1, 4'h0, 8'h04);
        repeat (8) @(posedge clock);
        bus(1'b0, 4'h0, 8'h00);
        chk("off_status", 8'h00, 8'(rd[3]));
        chk("off_pin", 8'h00, {6'h00, pin_oe, ana_en});
        bus(1'b1, 4'hC, 8'hFF);
        bus(1'b0, 4'hC, 8'h00);
        chk("unmapped", 8'h00, rd[7:0]);
        $display("pins and map done");
        nrst <= 1'b0;
        repeat (4) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        bus(1'b0, 4'h0, 8'h00);
        chk("sc_reset", `SC_RESET, rd[7:0]);
        bus(1'b0, 4'h8, 8'h00);
        chk("mask_reset", `MASK_RESET, rd[7:0]);
        $display("reset done");
        final_report;
    end
endmodule
